// [src/ops_pkg.sv]
package ops_pkg;
    // Program store size and pointer width
    localparam int OPS_PROG_DEPTH = 100;
    localparam int OPS_PC_W = 7;
    localparam int OPS_OPC_W = 5;
    localparam int OPS_OPT_W = 4;
    localparam int OPS_DATA_W = 16;
    localparam int OPS_INSN_W = OPS_OPC_W + OPS_OPT_W + OPS_DATA_W;
    localparam int OPS_PORTS = 13;
    // Instruction word field positions
    localparam int OPS_DATA_LSB = 0;
    localparam int OPS_OPT_LSB = 16;
    localparam int OPS_OPC_LSB = 20;
    // Reset values
    localparam logic [6:0] OPS_PC_RST = 7'h00;
    localparam logic [15:0] OPS_CNT_RST = 16'h0000;
    // Compare option codes: 0 counter, 1..13 input port, 14/15 stop status bits
    localparam logic [3:0] OPS_SEL_CNT = 4'h0;
    localparam logic [3:0] OPS_SEL_EXT1 = 4'he;
    localparam logic [3:0] OPS_SEL_EXT2 = 4'hf;
    // Opcodes handled by the sequencer; all others are handed out as actions
    localparam logic [4:0] OPS_OP_NOP = 5'h00;
    localparam logic [4:0] OPS_OP_CNT_INC = 5'h01;
    localparam logic [4:0] OPS_OP_CNT_CLR = 5'h02;
    localparam logic [4:0] OPS_OP_JMP = 5'h03;
    localparam logic [4:0] OPS_OP_JNE = 5'h04;
    localparam logic [4:0] OPS_OP_JEQ = 5'h05;
    localparam logic [4:0] OPS_OP_WAIT = 5'h06;
    localparam logic [4:0] OPS_OP_CMP = 5'h07;
    localparam logic [4:0] OPS_OP_STOP_EN = 5'h08;
    localparam logic [4:0] OPS_OP_PAUSE_EN = 5'h09;
    typedef enum logic [2:0] {
        OPS_IDLE = 3'b001,
        OPS_RUN = 3'b010,
        OPS_PAUSE = 3'b100
    } ops_state_t;
endpackage

// [src/ops_sequencer.sv]
module ops_sequencer
    import ops_pkg::*;
#(
    parameter int PROG_DEPTH = OPS_PROG_DEPTH,
    parameter int NUM_PORTS = OPS_PORTS
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // Program load port (host link writes the store)
    input wire logic prog_we_i,
    input wire logic [OPS_PC_W-1:0] prog_addr_i,
    input wire logic [OPS_INSN_W-1:0] prog_data_i,
    // Run control
    input wire logic run_i,
    input wire logic [OPS_PC_W-1:0] stop_target_i,
    // Live host command pass-through
    input wire logic host_cmd_valid_i,
    input wire logic [OPS_INSN_W-1:0] host_cmd_i,
    // Condition sources
    input wire logic [NUM_PORTS-1:0] port_in_i,
    input wire logic [1:0] ext_stop_i,
    input wire logic start_pause_key_in_i,
    input wire logic reset_stop_key_in_i,
    // Status
    output logic running_o,
    output logic paused_o,
    output logic [OPS_PC_W-1:0] pc_o,
    output logic [OPS_DATA_W-1:0] counter_o,
    output logic cmp_flag_o,
    output logic stop_en_o,
    output logic pause_en_o,
    // Actions for the rest of the controller
    output logic action_valid_o,
    output logic [OPS_INSN_W-1:0] action_o,
    output logic action_from_host_o
);
    ////////////////////////////////////////////////////////////////////////
    logic [OPS_INSN_W-1:0] prog_mem [PROG_DEPTH];
    ops_state_t state;
    logic [OPS_PC_W-1:0] pc;
    logic [OPS_DATA_W-1:0] counter;
    logic cmp_flag;
    logic stop_en;
    logic pause_en;
    logic sp_key_q;
    logic rs_key_q;
    logic [OPS_INSN_W-1:0] insn;
    logic [OPS_OPC_W-1:0] opc;
    logic [OPS_OPT_W-1:0] opt;
    logic [OPS_DATA_W-1:0] data;
    logic [OPS_PC_W-1:0] target;
    logic exec;
    logic sp_pulse;
    logic rs_pulse;
    logic [OPS_DATA_W-1:0] operand;
    logic cond_bit;
    logic wait_ok;
    logic [OPS_PC_W-1:0] next_pc;
    logic [OPS_PC_W-1:0] pc_inc;
    logic pc_top;
    ////////////////////////////////////////////////////////////////////////
    // Program store; writes allowed any time, read is combinational
    always_ff @(posedge clk_i) begin
        if (prog_we_i && (int'(prog_addr_i) < PROG_DEPTH)) begin
            prog_mem[prog_addr_i] <= prog_data_i;
        end
    end

    assign insn = prog_mem[pc];
    assign opc = insn[OPS_OPC_LSB +: OPS_OPC_W];
    assign opt = insn[OPS_OPT_LSB +: OPS_OPT_W];
    assign data = insn[OPS_DATA_LSB +: OPS_DATA_W];
    // Targets beyond the store are clamped to the last slot
    assign target = (data >= OPS_DATA_W'(PROG_DEPTH)) ? OPS_PC_W'(PROG_DEPTH - 1)
                                                     : data[OPS_PC_W-1:0];
    assign exec = (state == OPS_RUN);

    ////////////////////////////////////////////////////////////////////////
    // Key edge detect: a falling edge marks the start of a low pulse
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sp_key_q <= 1'b1;
            rs_key_q <= 1'b1;
        end else begin
            sp_key_q <= start_pause_key_in_i;
            rs_key_q <= reset_stop_key_in_i;
        end
    end

    assign sp_pulse = pause_en && sp_key_q && !start_pause_key_in_i;
    assign rs_pulse = stop_en && rs_key_q && !reset_stop_key_in_i;

    ////////////////////////////////////////////////////////////////////////
    // Operand and condition select, shared by compare and wait
    always_comb begin
        operand = OPS_CNT_RST;
        cond_bit = 1'b0;
        case (opt)
            OPS_SEL_CNT: begin
                operand = counter;
                cond_bit = cmp_flag;
            end
            OPS_SEL_EXT1: begin
                cond_bit = ext_stop_i[0];
                operand = {15'h0000, cond_bit};
            end
            OPS_SEL_EXT2: begin
                cond_bit = ext_stop_i[1];
                operand = {15'h0000, cond_bit};
            end
            default: begin
                if (int'(opt) <= NUM_PORTS) begin
                    cond_bit = port_in_i[opt - 4'h1];
                end
                operand = {15'h0000, cond_bit};
            end
        endcase
    end

    // Option 0 waits on the compare flag, others on a source level
    assign wait_ok = (cond_bit == data[0]);

    ////////////////////////////////////////////////////////////////////////
    // Next pointer
    assign pc_top = (pc == OPS_PC_W'(PROG_DEPTH - 1));
    assign pc_inc = pc_top ? pc : pc + 7'h01;

    always_comb begin
        next_pc = pc_inc;
        case (opc)
            OPS_OP_JMP: next_pc = target;
            OPS_OP_JEQ: next_pc = cmp_flag ? target : pc_inc;
            OPS_OP_JNE: next_pc = !cmp_flag ? target : pc_inc;
            OPS_OP_WAIT: next_pc = wait_ok ? pc_inc : pc;
            default: next_pc = pc_inc;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Run state; stop key has priority over pause key when running or paused, in idle the pause key starts a run
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state <= OPS_IDLE;
        end else begin
            case (state)
                OPS_IDLE: begin
                    if (run_i) begin
                        state <= OPS_RUN;
                    end else if (sp_pulse) begin
                        state <= OPS_RUN;
                    end
                end
                OPS_RUN: begin
                    if (rs_pulse) begin
                        state <= OPS_IDLE;
                    end else if (sp_pulse) begin
                        state <= OPS_PAUSE;
                    end else if (pc_top && (next_pc == pc) && (opc != OPS_OP_WAIT)) begin
                        state <= OPS_IDLE; // Ran off the end of the store
                    end
                end
                OPS_PAUSE: begin
                    if (rs_pulse) begin
                        state <= OPS_IDLE;
                    end else if (sp_pulse) begin
                        state <= OPS_RUN;
                    end
                end
                default: state <= OPS_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Program pointer
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pc <= OPS_PC_RST;
        end else if (rs_pulse) begin
            pc <= stop_target_i;
        end else if (exec) begin
            pc <= next_pc;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Loop counter
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            counter <= OPS_CNT_RST;
        end else if (exec && !rs_pulse && (opc == OPS_OP_CNT_INC)) begin
            counter <= counter + 16'h0001;
        end else if (exec && !rs_pulse && (opc == OPS_OP_CNT_CLR)) begin
            counter <= OPS_CNT_RST;
        end
    end

    // Compare flag
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cmp_flag <= 1'b0;
        end else if (exec && !rs_pulse && (opc == OPS_OP_CMP)) begin
            cmp_flag <= (operand == data);
        end
    end

    // Key enables: only program ops set them, and they stay set until reset
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            stop_en <= 1'b0;
            pause_en <= 1'b0;
        end else if (exec && !rs_pulse) begin
            if (opc == OPS_OP_STOP_EN) begin
                stop_en <= stop_en | data[0];
            end
            if (opc == OPS_OP_PAUSE_EN) begin
                pause_en <= pause_en | data[0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Action output; host commands win a shared cycle, program op is dropped
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            action_valid_o <= 1'b0;
            action_o <= '0;
            action_from_host_o <= 1'b0;
        end else if (host_cmd_valid_i) begin
            action_valid_o <= 1'b1;
            action_o <= host_cmd_i;
            action_from_host_o <= 1'b1;
        end else begin
            action_valid_o <= exec && !rs_pulse && (opc > OPS_OP_PAUSE_EN);
            action_o <= insn;
            action_from_host_o <= 1'b0;
        end
    end

    // Registered status copies
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            running_o <= 1'b0;
            paused_o <= 1'b0;
            pc_o <= OPS_PC_RST;
            counter_o <= OPS_CNT_RST;
            cmp_flag_o <= 1'b0;
            stop_en_o <= 1'b0;
            pause_en_o <= 1'b0;
        end else begin
            running_o <= (state == OPS_RUN);
            paused_o <= (state == OPS_PAUSE);
            pc_o <= pc;
            counter_o <= counter;
            cmp_flag_o <= cmp_flag;
            stop_en_o <= stop_en;
            pause_en_o <= pause_en;
        end
    end
endmodule

// [verif/ops_sequencer_assertions.sv]
module ops_sequencer_chk
    import ops_pkg::*;
(
    // Clock, reset and inputs
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [OPS_PC_W-1:0] stop_target_i,
    input wire logic host_cmd_valid_i,
    input wire logic [OPS_INSN_W-1:0] host_cmd_i,
    input wire logic reset_stop_key_in_i,
    // Status and actions
    input wire logic running_o,
    input wire logic paused_o,
    input wire logic [OPS_PC_W-1:0] pc_o,
    input wire logic [OPS_DATA_W-1:0] counter_o,
    input wire logic stop_en_o,
    input wire logic pause_en_o,
    input wire logic action_valid_o,
    input wire logic [OPS_INSN_W-1:0] action_o,
    input wire logic action_from_host_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    ////////////////////////////////////////////////////////////////////////////////
    // Counter only steps by one or clears
    cnt_step_a: assert property ($changed(counter_o) |->
        counter_o == $past(counter_o) + 16'h0001 || counter_o == 16'h0000)
        else $error("counter moved other than by one or clear");
    pc_range_a: assert property (pc_o < 7'h64)
        else $error("pointer beyond program store");
    stop_sticky_a: assert property (stop_en_o |=> stop_en_o)
        else $error("stop enable dropped");
    pause_sticky_a: assert property (pause_en_o |=> pause_en_o)
        else $error("pause enable dropped");
    run_excl_a: assert property (!(running_o && paused_o))
        else $error("running and paused together");
    // Pointer frozen across a pause
    pause_hold_a: assert property (paused_o ##1 paused_o |-> $stable(pc_o))
        else $error("pointer moved while paused");
    // Live command appears one edge later, even mid-program
    host_pass_a: assert property (host_cmd_valid_i |=> action_valid_o &&
        action_from_host_o && action_o == $past(host_cmd_i))
        else $error("host command not passed through");
    key_stop_a: assert property (stop_en_o && $fell(reset_stop_key_in_i) |->
        ##[1:4] (pc_o == stop_target_i && !running_o))
        else $error("stop key did not load pointer");
    cover property (host_cmd_valid_i);
    cover property ($rose(paused_o));
    cover property (stop_en_o && $fell(reset_stop_key_in_i));
endmodule
////////////////////////////////////////////////////////////////////////////////
bind ops_sequencer ops_sequencer_chk i_chk (.clk_i(clk_i), .resetn_i(resetn_i),
    .stop_target_i(stop_target_i), .host_cmd_valid_i(host_cmd_valid_i),
    .host_cmd_i(host_cmd_i), .reset_stop_key_in_i(reset_stop_key_in_i),
    .running_o(running_o), .paused_o(paused_o), .pc_o(pc_o), .counter_o(counter_o),
    .stop_en_o(stop_en_o), .pause_en_o(pause_en_o), .action_valid_o(action_valid_o),
    .action_o(action_o), .action_from_host_o(action_from_host_o));

// [verif/ops_key_model.sv]
module ops_key_model (
    // Clock
    input wire logic clk_i,
    // Key lines, pulled up while released
    output logic start_pause_key_in_o,
    output logic reset_stop_key_in_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Released keys sit at the pull-up level
    initial begin
        start_pause_key_in_o = 1'b1;
        reset_stop_key_in_o = 1'b1;
    end
    // Held low three cycles so a sampled falling edge cannot be missed
    task automatic press(input bit which);
        @(negedge clk_i);
        if (which) reset_stop_key_in_o = 1'b0;
        else start_pause_key_in_o = 1'b0;
        repeat (3) @(negedge clk_i);
        start_pause_key_in_o = 1'b1;
        reset_stop_key_in_o = 1'b1;
        repeat (6) @(negedge clk_i);
    endtask
endmodule

// [verif/tb_offline_program_sequencer.sv]
module tb_offline_program_sequencer import ops_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic prog_we_i = 1'b0;
    logic [OPS_PC_W-1:0] prog_addr_i = 7'h00;
    logic [OPS_INSN_W-1:0] prog_data_i = '0;
    logic run_i = 1'b0;
    logic [OPS_PC_W-1:0] stop_target_i = 7'h00;
    logic host_cmd_valid_i = 1'b0;
    logic [OPS_INSN_W-1:0] host_cmd_i = '0;
    logic [OPS_PORTS-1:0] port_in_i = '0;
    logic sp_key, rs_key, running_o, paused_o, cmp_flag_o, stop_en_o, pause_en_o;
    logic [OPS_PC_W-1:0] pc_o;
    logic [OPS_DATA_W-1:0] counter_o;
    logic [1:0] ext_stop_i = 2'h0;
    logic action_valid_o, action_from_host_o;
    logic [OPS_INSN_W-1:0] action_o;
    int err_total = 0;
    int cmp_count = 0;
    int cycles = 0;
    ////////////////////////////////////////////////////////////////////////////////
    ops_sequencer i_dut (.clk_i(clk_i), .resetn_i(resetn_i), .prog_we_i(prog_we_i),
        .prog_addr_i(prog_addr_i), .prog_data_i(prog_data_i), .run_i(run_i),
        .stop_target_i(stop_target_i), .host_cmd_valid_i(host_cmd_valid_i),
        .host_cmd_i(host_cmd_i), .port_in_i(port_in_i), .ext_stop_i(ext_stop_i),
        .start_pause_key_in_i(sp_key), .reset_stop_key_in_i(rs_key),
        .running_o(running_o), .paused_o(paused_o), .pc_o(pc_o), .counter_o(counter_o),
        .cmp_flag_o(cmp_flag_o), .stop_en_o(stop_en_o), .pause_en_o(pause_en_o),
        .action_valid_o(action_valid_o), .action_o(action_o),
        .action_from_host_o(action_from_host_o));
    ops_key_model i_keys (.clk_i(clk_i), .start_pause_key_in_o(sp_key),
        .reset_stop_key_in_o(rs_key));
    ////////////////////////////////////////////////////////////////////////////////
    // Clock and hang guard
    always #5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            tally_and_finish();
        end
    end
    function automatic logic [OPS_INSN_W-1:0] ins(logic [4:0] op, logic [3:0] opt,
        logic [15:0] d);
        return {op, opt, d};
    endfunction
    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    // Whole instruction words handed out on the action port
    task automatic check_word(input string name, input logic [OPS_INSN_W-1:0] exp,
        input logic [OPS_INSN_W-1:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic tally_and_finish();
        if (err_total == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Count loop, wait on a port, port compare, taken jump, then keys
    initial begin
        logic [OPS_INSN_W-1:0] prog [16];
        logic [15:0] n;
        void'($urandom(58));
        n = 16'($urandom_range(20, 2));
        stop_target_i = 7'($urandom_range(99, 0));
        port_in_i = 13'($urandom) & 13'h1ffe;
        ext_stop_i = {1'b0, 1'($urandom)};
        prog = '{ins(OPS_OP_CNT_CLR, 4'h0, 16'h0), ins(OPS_OP_CNT_INC, 4'h0, 16'h0),
            ins(OPS_OP_CMP, OPS_SEL_CNT, n), ins(OPS_OP_JNE, 4'h0, 16'h1),
            ins(OPS_OP_STOP_EN, 4'h0, 16'h1), ins(OPS_OP_PAUSE_EN, 4'h0, 16'h1),
            ins(OPS_OP_WAIT, 4'h1, 16'h1), ins(OPS_OP_CMP, 4'h1, 16'h1),
            ins(OPS_OP_JEQ, 4'h0, 16'ha), ins(OPS_OP_JMP, 4'h0, 16'h9),
            ins(OPS_OP_JMP, 4'h0, 16'ha), ins(5'h1f, 4'($urandom), 16'($urandom)),
            ins(OPS_OP_CMP, OPS_SEL_EXT1, 16'h1), ins(OPS_OP_WAIT, OPS_SEL_EXT2, 16'h1),
            ins(OPS_OP_CNT_CLR, 4'h0, 16'h0), ins(OPS_OP_JMP, 4'h0, 16'hf)};
        repeat (6) @(negedge clk_i);
        resetn_i = 1'b1;
        check("pc_rst", 16'h0, {9'h0, pc_o});
        for (int i = 0; i < 16; i++) begin
            @(negedge clk_i);
            prog_we_i = 1'b1;
            prog_addr_i = 7'(i);
            prog_data_i = prog[i];
        end
        @(negedge clk_i);
        prog_we_i = 1'b0;
        run_i = 1'b1;
        @(negedge clk_i);
        run_i = 1'b0;
        repeat (3 * n + 20) @(negedge clk_i);
        check("pc_wait", 16'h6, {9'h0, pc_o});
        check("counter", n, counter_o);
        check("flag", 16'h1, {15'h0, cmp_flag_o});
        host_cmd_i = ins(5'h10, 4'($urandom), 16'($urandom));
        host_cmd_valid_i = 1'b1;
        @(negedge clk_i);
        host_cmd_valid_i = 1'b0;
        check("host_valid", 16'h3, {14'h0, action_valid_o, action_from_host_o});
        check_word("host_word", host_cmd_i, action_o);
        port_in_i[0] = 1'b1;
        repeat (10) @(negedge clk_i);
        check("pc_jump", 16'ha, {9'h0, pc_o});
        check("enables", 16'h3, {14'h0, stop_en_o, pause_en_o});
        i_keys.press(1'b0);
        check("paused", 16'h1, {14'h0, running_o, paused_o});
        i_keys.press(1'b0);
        check("resumed", 16'h2, {14'h0, running_o, paused_o});
        i_keys.press(1'b1);
        check("pc_stop", {9'h0, stop_target_i}, {9'h0, pc_o});
        check("stopped", 16'h0, {15'h0, running_o});
        // Second program from slot 11: action, stop-bit compare, stop-bit wait, clear
        stop_target_i = 7'h0b;
        i_keys.press(1'b1);
        check("pc_load", 16'hb, {9'h0, pc_o});
        run_i = 1'b1;
        @(negedge clk_i);
        run_i = 1'b0;
        @(negedge clk_i);
        check("act_valid", 16'h2, {14'h0, action_valid_o, action_from_host_o});
        check_word("act_word", prog[11], action_o);
        repeat (6) @(negedge clk_i);
        check("pc_ext_wait", 16'hd, {9'h0, pc_o});
        check("ext_flag", {15'h0, ext_stop_i[0]}, {15'h0, cmp_flag_o});
        ext_stop_i[1] = 1'b1;
        repeat (6) @(negedge clk_i);
        check("pc_end", 16'hf, {9'h0, pc_o});
        check("cnt_clr", 16'h0, counter_o);
        tally_and_finish();
    end
endmodule
